//--- rtl/tvf_defs.svh
// tvf_defs.svh: offsets, field positions, reset values and sizes of the tx virtual fifo banks
// assumes: included by bare name, once per compile unit thanks to the guard
`ifndef TVF_DEFS_SVH
`define TVF_DEFS_SVH

// ***************************************************************
// register offsets on the plain register port
// ***************************************************************
`define TVF_ADDR_W          20
`define TVF_WIDTH_A_OFS     20'h30903
`define TVF_PCNT_A_OFS      20'h30927
`define TVF_PCNT_B_OFS      20'h30A27
`define TVF_WIDTH_B_OFS     20'h30A30
`define TVF_OWN_A_BASE      20'h30940
`define TVF_OWN_B_BASE      20'h30A40
`define TVF_THR_IDX         20'h00000
`define TVF_STAT_IDX        20'h00001
`define TVF_MASK_IDX        20'h00002
`define TVF_DEPTH_IDX       20'h00003
`define TVF_FULL_IDX        20'h00004

// ***************************************************************
// fields and reset values
// ***************************************************************
`define TVF_SIDE_EOP        0
`define TVF_EV_FULL         0
`define TVF_EV_OVF          1
`define TVF_EV_NULL         2
`define TVF_EV_UNDER        3
`define TVF_WIDTH_RST       8'h00
`define TVF_PCNT_RST        8'h00
`define TVF_THR_RST         32'h00000000
`define TVF_MASK_RST        4'h0

// ***************************************************************
// storage sizes
// ***************************************************************
`define TVF_BANKS           4
`define TVF_LINES_PER_BANK  256
`define TVF_MEM_LINES       1024
`define TVF_DATA_BYTES_32   2048
`define TVF_CTRL_SHIFT      2

`endif

//--- rtl/tvf_pkg.sv
// tvf_pkg.sv: types shared by the tx virtual fifo bank modules
// assumes: tvf_defs.svh is on the include path
`include "tvf_defs.svh"
package tvf_pkg;

	typedef enum logic [1:0] {
		TVF_W32  = 2'h0,
		TVF_W64  = 2'h1,
		TVF_W128 = 2'h2,
		TVF_WRSV = 2'h3
	} tvf_width_t;

	// one stored line: 16 data bytes plus 4 control bytes
	typedef struct packed {
		logic [127:0] data;
		logic [15:0]  be;
		logic [15:0]  side;
	} tvf_line_t;

	typedef struct packed {
		logic [9:0]  wptr;
		logic [9:0]  rptr;
		logic [10:0] level;
		logic        full;
	} tvf_part_st_t;

	typedef struct packed {
		logic [7:0]                          bw;
		logic [7:0]                          pc;
		logic [31:0]                         thr;
		logic [3:0]                          stat;
		logic [3:0]                          mask;
		logic [31:0]                         rdata;
		logic                                irq;
		logic                                rd_valid;
		tvf_line_t                           rd_line;
		logic [31:0]                         full_prev;
		logic [3:0][1:0]                     beat;
		tvf_line_t [3:0]                     lbuf;
		tvf_line_t [`TVF_MEM_LINES-1:0]      mem;
	} tvf_top_st_t;

endpackage : tvf_pkg

//--- rtl/tvf_part_if.sv
// tvf_part_if.sv: signals between the top and one partition pointer keeper
// assumes: both ends run on core_clk_i
`timescale 1ns/1ps
interface tvf_part_if;
	logic        push;
	logic        pop;
	logic        flush;
	logic        thr_full;
	logic [10:0] plines;
	logic [9:0]  wptr;
	logic [9:0]  rptr;
	logic [10:0] level;
	logic        full;
	logic        empty;

	modport ctl (
		input  push, pop, flush, thr_full, plines,
		output wptr, rptr, level, full, empty
	);
	modport top (
		output push, pop, flush, thr_full, plines,
		input  wptr, rptr, level, full, empty
	);
endinterface : tvf_part_if

//--- rtl/tvf_part_ctl.sv
// tvf_part_ctl.sv: write/read pointers, fill level and full flag of one virtual partition
// assumes: the top never pushes into a full partition nor pops an empty one
`timescale 1ns/1ps
module tvf_part_ctl
	import tvf_pkg::*;
(
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	tvf_part_if.ctl   pif
);

	tvf_part_st_t q;
	tvf_part_st_t d;
	logic [10:0]  thr;
	logic [10:0]  lvl;

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb
	begin
		d = q;
		// three quarters, or the whole partition
		thr = pif.thr_full ? pif.plines : 11'(pif.plines - (pif.plines >> 2));
		lvl = 11'(q.level + 11'(pif.push) - 11'(pif.pop));
		d.level = lvl;
		if (pif.push)
		begin
			d.wptr = (q.wptr == 10'(pif.plines - 11'h001)) ? 10'h000 : 10'(q.wptr + 10'h001);
		end
		if (pif.pop)
		begin
			d.rptr = (q.rptr == 10'(pif.plines - 11'h001)) ? 10'h000 : 10'(q.rptr + 10'h001);
		end
		// flag only moves on a whole line, and holds until the level is below threshold
		if (pif.push)
		begin
			d.full = (lvl >= thr);
		end
		else if (lvl < thr)
		begin
			d.full = 1'b0;
		end
		if (pif.flush)
		begin
			d = '0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign pif.wptr  = q.wptr;
	assign pif.rptr  = q.rptr;
	assign pif.level = q.level;
	assign pif.full  = q.full;
	assign pif.empty = (q.level == 11'h000);

endmodule : tvf_part_ctl

//--- rtl/tvf_top.sv
// tvf_top.sv: transmit virtual fifo banks with line assembly, storage and register port
// assumes: fabric writer, read-side arbiter and software all on core_clk_i
//
// Notes on behaviour
// - Four dual-port banks of 256 lines of 160 bits hold data plus sideband control.
// - Each bank splits into at most eight equal partitions, 32 across the banks.
// - Write and read pointers are kept inside for every partition.
// - A per-partition full flag goes back to the writer so it can stop in time.
// - Data enters through 32- or 64-bit lanes per bank or pair, or one 128-bit port.
// - Every write lane carries its own sideband control beside the data.
// - Data depth is 2K bytes in 32-bit mode, times two or four, over the count.
// - Control depth is a quarter of the data depth of the partition.
// - The width register has two bits per bank: 00 32-bit, 01 64-bit, 10 128-bit.
// - The count register has two bits per bank: 00 one, 01 two, 10 four, 11 eight.
// - Width and count sit at 30903/30927 for interface_a and 30A30/30A27 for interface_b.
// - The fourth bank uses bits 6 and 7 with the same codes.
// - A completed line with all sixteen byte_enables low is dropped, pointer unmoved.
// - Full is three-quarters or whole, updated per line, held until below threshold.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
`include "tvf_defs.svh"
module tvf_top
	import tvf_pkg::*;
#(
	parameter logic IF_SEL = 1'b0
)
(
	input  wire logic                    core_clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic [`TVF_ADDR_W-1:0]  reg_addr_i,
	input  wire logic [31:0]             reg_wdata_i,
	input  wire logic                    reg_wr_i,
	input  wire logic                    reg_rd_i,
	output logic      [31:0]             reg_rdata_o,
	input  wire logic [3:0]              wr_en_i,
	input  wire logic [3:0][2:0]         wr_part_i,
	input  wire logic [3:0][31:0]        wr_data_i,
	input  wire logic [3:0][3:0]         wr_be_i,
	input  wire logic [3:0][3:0]         wr_side_i,
	output logic      [31:0]             full_o,
	input  wire logic                    rd_en_i,
	input  wire logic [4:0]              rd_fifo_i,
	output logic                         rd_valid_o,
	output tvf_line_t                    rd_line_o,
	output logic                         irq_o
);

	// ***************************************************************
	// functions
	// ***************************************************************
	function automatic logic [1:0] tvf_fld(input logic [7:0] r, input logic [1:0] b);
		return r[{b, 1'b0} +: 2];
	endfunction : tvf_fld

	// the unused code 11 is served as 32-bit
	function automatic tvf_width_t tvf_w(input logic [7:0] r, input logic [1:0] b);
		tvf_width_t w;
		w = tvf_width_t'(tvf_fld(r, b));
		return (w == TVF_WRSV) ? TVF_W32 : w;
	endfunction : tvf_w

	// a bank heads a group unless a wider group below it already covers it
	function automatic logic tvf_is_lead(input logic [7:0] r, input logic [1:0] b);
		logic l;
		unique case (b)
			2'h0: l = 1'b1;
			2'h1: l = (tvf_w(r, 2'h0) == TVF_W32);
			2'h2: l = (tvf_w(r, 2'h0) != TVF_W128);
			2'h3: l = (tvf_w(r, 2'h0) != TVF_W128) && (tvf_w(r, 2'h2) == TVF_W32);
		endcase
		return l;
	endfunction : tvf_is_lead

	function automatic logic [10:0] tvf_plines(input tvf_width_t w, input logic [1:0] c);
		return 11'((11'(`TVF_LINES_PER_BANK) << w) >> c);
	endfunction : tvf_plines

	// select bits above the configured count are ignored
	function automatic logic [2:0] tvf_pmask(input logic [2:0] s, input logic [1:0] c);
		return s & ~(3'(3'h7 << c));
	endfunction : tvf_pmask

	function automatic logic [9:0] tvf_laddr(input logic [1:0] b, input logic [2:0] p,
		input logic [10:0] pl, input logic [9:0] ptr);
		return 10'(11'(b) * 11'(`TVF_LINES_PER_BANK) + 11'(p) * pl + 11'(ptr));
	endfunction : tvf_laddr

	function automatic logic [15:0] tvf_data_bytes(input tvf_width_t w, input logic [1:0] c);
		return 16'((16'(`TVF_DATA_BYTES_32) << w) >> c);
	endfunction : tvf_data_bytes

	// ***************************************************************
	// state and partition keepers
	// ***************************************************************
	tvf_top_st_t               q;
	tvf_top_st_t               d;
	logic [31:0]               push_v;
	logic [31:0]               pop_v;
	logic                      flush;
	logic [31:0]               full_v;
	logic [31:0]               empty_v;
	logic [31:0][10:0]         level_v;
	logic [31:0][10:0]         plines_v;
	logic [31:0][9:0]          wptr_v;
	logic [31:0][9:0]          rptr_v;
	logic [3:0]                ev;
	logic [3:0]                clr;
	tvf_width_t                w;
	logic [1:0]                c;
	logic [1:0]                slot;
	logic [4:0]                fid;
	logic [2:0]                p;
	logic                      last;
	logic                      eop;
	tvf_line_t                 line;
	logic [15:0]               dbytes;
	logic [`TVF_ADDR_W-1:0]    own;
	logic [`TVF_ADDR_W-1:0]    wid_ofs;
	logic [`TVF_ADDR_W-1:0]    pc_ofs;

	assign own     = IF_SEL ? `TVF_OWN_B_BASE : `TVF_OWN_A_BASE;
	assign wid_ofs = IF_SEL ? `TVF_WIDTH_B_OFS : `TVF_WIDTH_A_OFS;
	assign pc_ofs  = IF_SEL ? `TVF_PCNT_B_OFS : `TVF_PCNT_A_OFS;

	tvf_part_if pif [32] ();

	for (genvar i = 0; i < 32; i++)
	begin : g_part
		assign pif[i].push     = push_v[i];
		assign pif[i].pop      = pop_v[i];
		assign pif[i].flush    = flush;
		assign pif[i].thr_full = q.thr[i];
		assign pif[i].plines   = plines_v[i];
		assign plines_v[i]     = tvf_plines(tvf_w(q.bw, 2'(i / 8)), tvf_fld(q.pc, 2'(i / 8)));
		assign full_v[i]       = pif[i].full;
		assign empty_v[i]      = pif[i].empty;
		assign level_v[i]      = pif[i].level;
		assign wptr_v[i]       = pif[i].wptr;
		assign rptr_v[i]       = pif[i].rptr;

		tvf_part_ctl u_part (
			.core_clk_i (core_clk_i),
			.rst_n_i    (rst_n_i),
			.pif        (pif[i])
		);
	end

	// ***************************************************************
	// next state
	// ***************************************************************
	always_comb
	begin
		d = q;
		d.rd_valid = 1'b0;
		d.rdata = 32'h00000000;
		push_v = 32'h00000000;
		pop_v = 32'h00000000;
		flush = 1'b0;
		ev = 4'h0;
		clr = 4'h0;
		w = TVF_W32;
		c = 2'h0;
		slot = 2'h0;
		fid = 5'h00;
		p = 3'h0;
		last = 1'b0;
		eop = 1'b0;
		line = '0;
		dbytes = 16'h0000;

		// reshaping the banks empties every partition; stale pointers would be meaningless
		if (reg_wr_i)
		begin
			if (reg_addr_i == wid_ofs)
			begin
				d.bw = reg_wdata_i[7:0];
				flush = 1'b1;
			end
			if (reg_addr_i == pc_ofs)
			begin
				d.pc = reg_wdata_i[7:0];
				flush = 1'b1;
			end
			if (reg_addr_i == own + `TVF_THR_IDX)
			begin
				d.thr = reg_wdata_i;
			end
			if (reg_addr_i == own + `TVF_STAT_IDX)
			begin
				clr = reg_wdata_i[3:0];
			end
			if (reg_addr_i == own + `TVF_MASK_IDX)
			begin
				d.mask = reg_wdata_i[3:0];
			end
		end
		if (flush)
		begin
			d.beat = '0;
			d.lbuf = '0;
		end

		// each group head gathers 1, 2 or 4 lanes per beat into one 128-bit line
		for (int b = 0; b < `TVF_BANKS; b++)
		begin
			w = tvf_w(q.bw, 2'(b));
			c = tvf_fld(q.pc, 2'(b));
			if (!flush && wr_en_i[b] && tvf_is_lead(q.bw, 2'(b)))
			begin
				eop = 1'b0;
				for (int j = 0; j < 4; j++)
				begin
					if (j < (1 << w))
					begin
						slot = 2'(int'(q.beat[b]) * (1 << w) + j);
						d.lbuf[b].data[{slot, 5'h00} +: 32] = wr_data_i[2'(b + j)];
						d.lbuf[b].be[{slot, 2'h0} +: 4] = wr_be_i[2'(b + j)];
						d.lbuf[b].side[{slot, 2'h0} +: 4] = wr_side_i[2'(b + j)];
						eop = eop | wr_side_i[2'(b + j)][`TVF_SIDE_EOP];
					end
				end
				// an end of packet closes the line early, the missing slots stay disabled
				last = eop || (q.beat[b] == 2'((4 >> w) - 1));
				if (last)
				begin
					line = d.lbuf[b];
					d.lbuf[b] = '0;
					d.beat[b] = 2'h0;
					p = tvf_pmask(wr_part_i[b], c);
					fid = {2'(b), p};
					if (line.be == 16'h0000)
					begin
						ev[`TVF_EV_NULL] = 1'b1;
					end
					else if (level_v[fid] >= plines_v[fid])
					begin
						// writer ignored the full flag; the line is lost
						ev[`TVF_EV_OVF] = 1'b1;
					end
					else
					begin
						push_v[fid] = 1'b1;
						d.mem[tvf_laddr(2'(b), p, plines_v[fid], wptr_v[fid])] = line;
					end
				end
				else
				begin
					d.beat[b] = 2'(q.beat[b] + 2'h1);
				end
			end
		end

		// read side: one whole line per request, data one cycle later
		if (rd_en_i && !flush)
		begin
			if (empty_v[rd_fifo_i])
			begin
				ev[`TVF_EV_UNDER] = 1'b1;
			end
			else
			begin
				pop_v[rd_fifo_i] = 1'b1;
				d.rd_valid = 1'b1;
				d.rd_line = q.mem[tvf_laddr(rd_fifo_i[4:3], rd_fifo_i[2:0],
					plines_v[rd_fifo_i], rptr_v[rd_fifo_i])];
			end
		end

		// events win over a clear in the same cycle
		ev[`TVF_EV_FULL] = |(full_v & ~q.full_prev);
		d.full_prev = full_v;
		d.stat = (q.stat & ~clr) | ev;
		d.irq = |(d.stat & d.mask);

		if (reg_rd_i)
		begin
			dbytes = tvf_data_bytes(tvf_w(q.bw, 2'h0), tvf_fld(q.pc, 2'h0));
			if (reg_addr_i == wid_ofs)
			begin
				d.rdata = {24'h000000, q.bw};
			end
			else if (reg_addr_i == pc_ofs)
			begin
				d.rdata = {24'h000000, q.pc};
			end
			else if (reg_addr_i == own + `TVF_THR_IDX)
			begin
				d.rdata = q.thr;
			end
			else if (reg_addr_i == own + `TVF_STAT_IDX)
			begin
				d.rdata = {28'h0000000, q.stat};
			end
			else if (reg_addr_i == own + `TVF_MASK_IDX)
			begin
				d.rdata = {28'h0000000, q.mask};
			end
			else if (reg_addr_i == own + `TVF_DEPTH_IDX)
			begin
				d.rdata = {16'(dbytes >> `TVF_CTRL_SHIFT), dbytes};
			end
			else if (reg_addr_i == own + `TVF_FULL_IDX)
			begin
				d.rdata = full_v;
			end
		end
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	// line storage is not reset, only the control around it
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			q.bw        <= `TVF_WIDTH_RST;
			q.pc        <= `TVF_PCNT_RST;
			q.thr       <= `TVF_THR_RST;
			q.stat      <= 4'h0;
			q.mask      <= `TVF_MASK_RST;
			q.rdata     <= 32'h00000000;
			q.irq       <= 1'b0;
			q.rd_valid  <= 1'b0;
			q.rd_line   <= '0;
			q.full_prev <= 32'h00000000;
			q.beat      <= '0;
			q.lbuf      <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	assign reg_rdata_o = q.rdata;
	assign full_o      = full_v;
	assign rd_valid_o  = q.rd_valid;
	assign rd_line_o   = q.rd_line;
	assign irq_o       = q.irq;

endmodule : tvf_top

//--- verification/tvf_top_sva.sv
// tvf_top_sva.sv: port-level assertions for tvf_top, bound into every instance
// assumes: one clock domain, core_clk_i with synchronous active-low rst_n_i
`timescale 1ns/1ps
`include "tvf_defs.svh"
module tvf_top_sva
	import tvf_pkg::*;
#(
	parameter logic IF_SEL = 1'b0
)
(
	input wire logic                   core_clk_i,
	input wire logic                   rst_n_i,
	input wire logic [`TVF_ADDR_W-1:0] reg_addr_i,
	input wire logic [31:0]            reg_wdata_i,
	input wire logic                   reg_wr_i,
	input wire logic                   reg_rd_i,
	input wire logic [31:0]            reg_rdata_o,
	input wire logic [3:0]             wr_en_i,
	input wire logic [31:0]            full_o,
	input wire logic                   rd_en_i,
	input wire logic                   rd_valid_o,
	input wire tvf_line_t              rd_line_o,
	input wire logic                   irq_o
);
	localparam logic [19:0] WID = IF_SEL ? `TVF_WIDTH_B_OFS : `TVF_WIDTH_A_OFS;
	localparam logic [19:0] MSK = (IF_SEL ? `TVF_OWN_B_BASE : `TVF_OWN_A_BASE) + `TVF_MASK_IDX;

	// ***************************************************************
	// properties
	// ***************************************************************
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data not zero outside a read answer");
	unmap_zero_a: assert property (reg_rd_i && reg_addr_i == 20'h00000 |=> reg_rdata_o == 32'h0)
		else $error("unmapped read returned data");
	width_back_a: assert property (reg_rd_i && reg_addr_i == WID && $past(reg_wr_i)
		&& $past(reg_addr_i) == WID |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h000000FF))
		else $error("width register read back differs");
	rdv_cause_a: assert property (rd_valid_o |-> $past(rd_en_i))
		else $error("read valid without request");
	line_hold_a: assert property (!rd_valid_o |-> $stable(rd_line_o))
		else $error("read line moved without valid");
	mask_off_a: assert property (reg_wr_i && reg_addr_i == MSK && reg_wdata_i[3:0] == 4'h0
		|=> !irq_o)
		else $error("interrupt high with mask cleared");
	// a flag may only rise one cycle after a completing write beat
	full_rise_a: assert property (|(full_o & ~$past(full_o)) |-> |$past(wr_en_i))
		else $error("full rose without a write");
	full_fall_a: assert property (|(~full_o & $past(full_o)) |-> $past(rd_en_i)
		|| $past(rd_en_i, 2) || $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("full fell without read or flush");

	cover property (rd_valid_o);
	cover property (|full_o);
	cover property (irq_o);
endmodule : tvf_top_sva

bind tvf_top tvf_top_sva #(.IF_SEL(IF_SEL)) u_sva (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .wr_en_i(wr_en_i), .full_o(full_o),
	.rd_en_i(rd_en_i), .rd_valid_o(rd_valid_o), .rd_line_o(rd_line_o), .irq_o(irq_o));

//--- verification/tvf_fab_model.sv
// tvf_fab_model.sv: fabric writer that cuts one line into beats on the head lanes
// assumes: send_line is entered after a rising edge; bank 0 group only
`timescale 1ns/1ps
module tvf_fab_model
	import tvf_pkg::*;
(
	input  wire logic             core_clk_i,
	input  wire logic [31:0]      full_i,
	output logic      [3:0]       wr_en_o,
	output logic      [3:0][2:0]  wr_part_o,
	output logic      [3:0][31:0] wr_data_o,
	output logic      [3:0][3:0]  wr_be_o,
	output logic      [3:0][3:0]  wr_side_o
);
	bit blind = 1'b0;

	initial
	begin
		wr_en_o   = 4'h0;
		wr_part_o = '0;
		wr_data_o = '0;
		wr_be_o   = '0;
		wr_side_o = '0;
	end

	// ***************************************************************
	// line sender
	// ***************************************************************
	// the writer stops itself on a full flag unless blind is set to provoke an overflow
	task automatic send_line(input int lanes, input logic [2:0] part, input logic [4:0] f,
		input tvf_line_t ln, output bit ok);
		int s;
		ok = blind || !full_i[f];
		for (int b = 0; ok && b < 4 / lanes; b++)
		begin
			@(posedge core_clk_i);
			for (int j = 0; j < 4; j++)
			begin
				s = (b * lanes + j) % 4;
				wr_en_o[j]   <= (j == 0);
				wr_part_o[j] <= part;
				wr_data_o[j] <= (j < lanes) ? ln.data[32*s+:32] : 32'h0;
				wr_be_o[j]   <= (j < lanes) ? ln.be[4*s+:4] : 4'h0;
				wr_side_o[j] <= (j < lanes) ? ln.side[4*s+:4] : 4'h0;
			end
		end
		if (ok)
		begin
			@(posedge core_clk_i);
			wr_en_o <= 4'h0;
		end
	endtask : send_line
endmodule : tvf_fab_model

//--- verification/tvf_top_bench.sv
// tvf_top_bench.sv: self-checking bench with queue model of the bank 0 partitions
// assumes: u_dut on interface_a offsets, u_dut_b on interface_b, 100 MHz core_clk
`timescale 1ns/1ps
`include "tvf_defs.svh"
module tvf_top_bench
	import tvf_pkg::*;
;
	logic                   core_clk;
	logic                   rst_n;
	logic [`TVF_ADDR_W-1:0] reg_addr;
	logic [31:0]            reg_wdata;
	logic                   reg_wr;
	logic                   reg_rd;
	logic [31:0]            reg_rdata;
	logic [3:0]             wr_en;
	logic [3:0][2:0]        wr_part;
	logic [3:0][31:0]       wr_data;
	logic [3:0][3:0]        wr_be;
	logic [3:0][3:0]        wr_side;
	logic [31:0]            full;
	logic                   rd_en;
	logic [4:0]             rd_fifo;
	logic                   rd_valid;
	tvf_line_t              rd_line;
	logic                   irq;
	logic [31:0]            seed;
	int                     err_total;
	int                     total_checks;
	int                     cyc;
	int                     thr;
	int                     dbytes;
	int                     lines;
	bit                     ok;
	tvf_line_t              eop_ln;
	logic [31:0]            reg_rdata_b;
	logic [4:0]             f;
	tvf_line_t              mq[32][$];

	localparam logic [19:0] STA = `TVF_OWN_A_BASE + `TVF_STAT_IDX;

	tvf_top u_dut (.core_clk_i(core_clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.wr_en_i(wr_en), .wr_part_i(wr_part), .wr_data_i(wr_data), .wr_be_i(wr_be),
		.wr_side_i(wr_side), .full_o(full), .rd_en_i(rd_en), .rd_fifo_i(rd_fifo),
		.rd_valid_o(rd_valid), .rd_line_o(rd_line), .irq_o(irq));
	tvf_top #(.IF_SEL(1'b1)) u_dut_b (.core_clk_i(core_clk), .rst_n_i(rst_n),
		.reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata_b), .wr_en_i(wr_en), .wr_part_i(wr_part), .wr_data_i(wr_data),
		.wr_be_i(wr_be), .wr_side_i(wr_side), .full_o(), .rd_en_i(rd_en), .rd_fifo_i(rd_fifo),
		.rd_valid_o(), .rd_line_o(), .irq_o());
	tvf_fab_model u_fab (.core_clk_i(core_clk), .full_i(full), .wr_en_o(wr_en),
		.wr_part_o(wr_part), .wr_data_o(wr_data), .wr_be_o(wr_be), .wr_side_o(wr_side));

	// ***************************************************************
	// helpers
	// ***************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	task automatic chk(input logic [159:0] got, input logic [159:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict

	task automatic bus(input logic w, input logic r, input logic [19:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= w;
		reg_rd    <= r;
		reg_addr  <= a;
		reg_wdata <= d;
	endtask : bus

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [19:0] a, input logic [31:0] exp);
		bus(1'b0, 1'b1, a, 32'h0);
		bus(1'b0, 1'b0, 20'h0, 32'h0);
		#1;
		chk(reg_rdata, exp);
	endtask : rd

	task automatic wr(input logic [19:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
		bus(1'b0, 1'b0, 20'h0, 32'h0);
	endtask : wr

	// write then read back with no gap; a configuration write empties every partition
	task automatic cfg(input logic [7:0] bw, input logic [7:0] pc);
		bus(1'b1, 1'b0, `TVF_WIDTH_A_OFS, {24'h0, bw});
		bus(1'b0, 1'b1, `TVF_WIDTH_A_OFS, 32'h0);
		bus(1'b1, 1'b0, `TVF_PCNT_A_OFS, {24'h0, pc});
		#1;
		chk(reg_rdata, {24'h0, bw});
		bus(1'b0, 1'b1, `TVF_PCNT_A_OFS, 32'h0);
		bus(1'b0, 1'b0, 20'h0, 32'h0);
		#1;
		chk(reg_rdata, {24'h0, pc});
		foreach (mq[i])
			mq[i].delete();
	endtask : cfg

	task automatic send(input int lanes, input logic [2:0] part, input logic nul);
		tvf_line_t ln;
		bit        ok;
		for (int k = 0; k < 5; k++)
		begin
			seed = lfsr(seed);
			ln[32*k+:32] = seed;
		end
		ln.side = ln.side & 16'hEEEE;
		ln.be = nul ? 16'h0000 : (ln.be | 16'h0001);
		u_fab.send_line(lanes, part, f, ln, ok);
		if (ok && !nul && mq[f].size() < lines)
			mq[f].push_back(ln);
		@(posedge core_clk);
		#1;
		chk(full[f], mq[f].size() >= thr);
	endtask : send

	task automatic pop();
		tvf_line_t e;
		logic      v;
		v = mq[f].size() != 0;
		if (v)
			e = mq[f].pop_front();
		@(posedge core_clk);
		rd_en   <= 1'b1;
		rd_fifo <= f;
		@(posedge core_clk);
		rd_en   <= 1'b0;
		#1;
		chk(rd_valid, v);
		if (v)
			chk(rd_line, e);
	endtask : pop

	// ***************************************************************
	// run
	// ***************************************************************
	always #5 core_clk = ~core_clk;

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end

	initial
	begin
		core_clk = 1'b0;
		rst_n = 1'b0;
		{reg_addr, reg_wdata, reg_wr, reg_rd, rd_en, rd_fifo} = '0;
		seed = 32'h2E904BB3;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`TVF_WIDTH_A_OFS, 32'h0);
		rd(`TVF_PCNT_A_OFS, 32'h0);
		rd(`TVF_OWN_A_BASE, 32'h0);
		rd(20'h00000, 32'h0);
		// the interface_b twin answers only its own offsets
		bus(1'b1, 1'b0, `TVF_WIDTH_B_OFS, 32'h00000050);
		bus(1'b1, 1'b0, `TVF_PCNT_B_OFS, 32'h000000A4);
		bus(1'b0, 1'b1, `TVF_WIDTH_B_OFS, 32'h0);
		bus(1'b0, 1'b1, `TVF_PCNT_B_OFS, 32'h0);
		#1;
		chk(reg_rdata_b, 32'h00000050);
		chk(reg_rdata, 32'h0);
		bus(1'b0, 1'b0, 20'h0, 32'h0);
		#1;
		chk(reg_rdata_b, 32'h000000A4);
		wr(STA - 1 + `TVF_MASK_IDX, 32'h0000000F);
		for (int w = 0; w < 3; w++)
			for (int c = 0; c < 4; c++)
			begin
				cfg({4{w[1:0]}}, {4{c[1:0]}});
				dbytes = (2048 << w) >> c;
				lines = (256 << w) >> c;
				thr = lines - lines / 4;
				rd(`TVF_OWN_A_BASE + `TVF_DEPTH_IDX, (dbytes >> 2) << 16 | dbytes);
				f = {2'h0, seed[2:0] & 3'((1 << c) - 1)};
				send(1 << w, seed[2:0], 1'b0);
				send(1 << w, seed[2:0], 1'b1);
				pop();
				pop();
				rd(STA, 32'h0000000C);
				chk(irq, 1'b1);
				wr(STA, 32'h0000000F);
				rd(STA, 32'h0);
				chk(irq, 1'b0);
			end
		// code 11 runs as 32-bit; an end of packet on the first beat closes a one-slot line
		cfg(8'hFF, 8'h00);
		rd(`TVF_OWN_A_BASE + `TVF_DEPTH_IDX, 32'h02000800);
		f = 5'h00;
		seed = lfsr(seed);
		eop_ln = {96'h0, seed, 32'h000F0001};
		u_fab.send_line(1, 3'h0, f, eop_ln, ok);
		mq[f].push_back(eop_ln);
		pop();
		cfg(8'h00, 8'h03);
		lines = 32;
		thr = 24;
		f = 5'h05;
		repeat (25) send(1, 3'h5, 1'b0);
		rd(STA, 32'h00000001);
		pop();
		@(posedge core_clk);
		#1;
		chk(full[5], 1'b0);
		wr(`TVF_OWN_A_BASE, 32'h00000020);
		rd(`TVF_OWN_A_BASE, 32'h00000020);
		thr = 32;
		repeat (9) send(1, 3'h5, 1'b0);
		// a writer that ignores the flag loses its line; the oldest line must survive
		u_fab.blind = 1'b1;
		send(1, 3'h5, 1'b0);
		rd(STA, 32'h00000003);
		pop();
		wr(STA - 1 + `TVF_MASK_IDX, 32'h0);
		@(posedge core_clk);
		#1;
		chk(irq, 1'b0);
		give_verdict();
	end
endmodule : tvf_top_bench
